// [common/tvec_pkg.sv]
package tvec_pkg;
    // Register offsets.
    localparam logic [7:0] TVEC_OFS_EVT_FLAGS = 8'h90;
    localparam logic [7:0] TVEC_OFS_EVT_EN    = 8'h92;
    localparam logic [7:0] TVEC_OFS_GEN_CTL   = 8'h94;
    localparam logic [7:0] TVEC_OFS_TX_CTL    = 8'h95;
    // Field positions.
    localparam int TVEC_BIT_SLOW_OSC   = 4;
    localparam int TVEC_BIT_CONFIG_PIN_OVERVOLTAGE_FAULT   = 3;
    localparam int TVEC_BIT_OVERTEMP   = 2;
    localparam int TVEC_BIT_CLR_POLICY = 7;
    localparam int TVEC_BIT_PD_RESET   = 6;
    localparam int TVEC_BIT_SOFT_RESET = 5;
    localparam int TVEC_BIT_SAMPLE_POL = 4;
    localparam int TVEC_POLL_LSB       = 2;
    localparam int TVEC_SHARE_LSB      = 0;
    localparam int TVEC_BIT_TX_CARRIER = 2;
    localparam int TVEC_BIT_TX_FRS     = 1;
    // Implemented bits; everything else is reserved and reads zero, except general control bit 7, the read-only policy strap.
    localparam logic [7:0] TVEC_EVT_MASK    = 8'h1c;
    localparam logic [7:0] TVEC_GEN_WR_MASK = 8'h7f;
    localparam logic [7:0] TVEC_TX_WR_MASK  = 8'h06;
    // Reset values.
    localparam logic [7:0] TVEC_RST_EVT_FLAGS = 8'h00;
    localparam logic [7:0] TVEC_RST_EVT_EN    = 8'h00;
    localparam logic [7:0] TVEC_RST_GEN_CTL   = 8'h04;
    localparam logic [7:0] TVEC_RST_TX_CTL    = 8'h00;
    // Timing.
    localparam int TVEC_CLK_PERIOD_NS  = 10;
    localparam int TVEC_POLL_BASE_NS   = 1000000;
    localparam int TVEC_POLL_BASE_CYC  = TVEC_POLL_BASE_NS / TVEC_CLK_PERIOD_NS;
    localparam int TVEC_POLL_CNT_W     = 21;
    // Serial slave states.
    typedef enum logic [3:0] {
        TVEC_I2C_IDLE     = 4'h0,
        TVEC_I2C_ADDR     = 4'h1,
        TVEC_I2C_ACK_ADDR = 4'h2,
        TVEC_I2C_PTR      = 4'h3,
        TVEC_I2C_ACK_PTR  = 4'h4,
        TVEC_I2C_WDATA    = 4'h5,
        TVEC_I2C_ACK_W    = 4'h6,
        TVEC_I2C_RDATA    = 4'h7,
        TVEC_I2C_RACK     = 4'h8
    } tvec_i2c_state_e;
endpackage

// [verilog/tvec_i2c_slave.sv]
`timescale 1ns/1ns
module tvec_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h20
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_pin,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    import tvec_pkg::*;

    logic [1:0]      scl_sync_q;
    logic [1:0]      sda_sync_q;
    logic            scl_d1_q;
    logic            sda_d1_q;
    logic            scl_s;
    logic            sda_s;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_cond;
    logic            stop_cond;
    tvec_i2c_state_e state_q;
    logic [3:0]      bit_cnt_q;
    logic [7:0]      shift_q;
    logic            rw_q;
    logic            nack_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_d1_q   <= 1'b1;
            sda_d1_q   <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_pin};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_d1_q   <= scl_sync_q[1];
            sda_d1_q   <= sda_sync_q[1];
        end
    end

    assign scl_s      = scl_sync_q[1];
    assign sda_s      = sda_sync_q[1];
    assign scl_rise   = scl_s & ~scl_d1_q;
    assign scl_fall   = ~scl_s & scl_d1_q;
    assign start_cond = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
    assign stop_cond  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

    // The pin is open drain: only a low is ever driven.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // On a read, reg_wdata carries the byte just loaded so the owner knows exactly which bits were seen.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= TVEC_I2C_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            rw_q      <= 1'b0;
            nack_q    <= 1'b0;
            sda_oe_n  <= 1'b1;
            reg_addr  <= 8'h00;
            reg_wdata <= 8'h00;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (reg_wr || reg_rd) begin
                reg_addr <= reg_addr + 8'h01;
            end
            if (start_cond) begin
                state_q   <= TVEC_I2C_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_n  <= 1'b1;
            end else if (stop_cond) begin
                state_q  <= TVEC_I2C_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                case (state_q)
                    TVEC_I2C_ADDR, TVEC_I2C_PTR, TVEC_I2C_WDATA: begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    TVEC_I2C_RACK: nack_q <= sda_s;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    TVEC_I2C_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                sda_oe_n <= 1'b0;
                                rw_q     <= shift_q[0];
                                state_q  <= TVEC_I2C_ACK_ADDR;
                            end else begin
                                state_q <= TVEC_I2C_IDLE;
                            end
                        end
                    end
                    TVEC_I2C_PTR: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_n <= 1'b0;
                            reg_addr <= shift_q;
                            state_q  <= TVEC_I2C_ACK_PTR;
                        end
                    end
                    TVEC_I2C_WDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_n  <= 1'b0;
                            reg_wdata <= shift_q;
                            reg_wr    <= 1'b1;
                            state_q   <= TVEC_I2C_ACK_W;
                        end
                    end
                    TVEC_I2C_ACK_ADDR, TVEC_I2C_RACK: begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == TVEC_I2C_RACK && nack_q) begin
                            sda_oe_n <= 1'b1;
                            state_q  <= TVEC_I2C_IDLE;
                        end else if (state_q == TVEC_I2C_RACK || rw_q) begin
                            shift_q   <= reg_rdata;
                            reg_wdata <= reg_rdata;
                            sda_oe_n  <= reg_rdata[7];
                            reg_rd    <= 1'b1;
                            state_q   <= TVEC_I2C_RDATA;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state_q  <= TVEC_I2C_PTR;
                        end
                    end
                    TVEC_I2C_ACK_PTR, TVEC_I2C_ACK_W: begin
                        sda_oe_n  <= 1'b1;
                        bit_cnt_q <= 4'h0;
                        state_q   <= TVEC_I2C_WDATA;
                    end
                    TVEC_I2C_RDATA: begin
                        if (bit_cnt_q == 4'h7) begin
                            sda_oe_n <= 1'b1;
                            state_q  <= TVEC_I2C_RACK;
                        end else begin
                            sda_oe_n  <= shift_q[6];
                            shift_q   <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// [verilog/tvec_regs.sv]
`timescale 1ns/1ns
// Function
// RULE1 - Slow oscillator expiry sets event bit 4.
// RULE2 - Unattached CC overvoltage sets event bit 3.
// RULE3 - Overtemperature shutdown sets event bit 2.
// RULE4 - Enable bits per event, reset masked.
// RULE5 - Clear policy: write-one or clear on read.
// RULE6 - Policy covers vendor flags, not packet start.
// RULE7 - Bit 6 resets PD state machines, self-clears.
// RULE8 - Bit 5 restores all defaults, self-clears.
// RULE9 - Host reprograms settings after soft reset.
// RULE10 - Bit 4 picks continuous or pre-toggle sampling.
// RULE11 - Poll interval codes 1/2/8/16 ms, reset 01.
// RULE12 - Source share codes 30/10/50/60 percent.
// RULE13 - General control resets to 0x04.
// RULE14 - Transmit bit 1 sends fast role swap.
// RULE15 - Transmit bit 2 selects continuous carrier.
// RULE16 - Alert while any enabled flag set.
// RULE17 - Reserved bits read zero, writes ignored.
module tvec_regs #(
    parameter logic [6:0] DEV_ADDR         = 7'h20,
    parameter int         POLL_BASE_CYCLES = tvec_pkg::TVEC_POLL_BASE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic scl_pin,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic slow_osc_timer_expired,
    input  wire logic config_pin_over_limit,
    input  wire logic port_unattached,
    input  wire logic overtemp_shutdown,
    input  wire logic clear_policy_strap,
    input  wire logic drp_toggle_active,
    input  wire logic role_toggle_due,
    input  wire logic pd_phy_reset_done,
    input  wire logic fast_role_swap_sent,
    output logic      vendor_alert,
    output logic      pd_phy_state_reset,
    output logic      whole_chip_soft_reset,
    output logic      config_pin_sample,
    output logic [1:0] toggle_source_share,
    output logic      fast_role_swap_req,
    output logic      test_carrier_continuous_sel
);
    import tvec_pkg::*;

    localparam int PIN_N = 5;

    logic [1:0]                 rst_sync_q;
    logic                       rst_int_n;
    logic [PIN_N-1:0]           pin_raw;
    logic [PIN_N-1:0]           pin_s;
    logic                       osc_s;
    logic                       cc_s;
    logic                       unatt_s;
    logic                       ot_s;
    logic                       strap_s;
    logic [7:0]                 reg_addr;
    logic [7:0]                 reg_wdata;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [7:0]                 reg_rdata;
    logic [7:0]                 flags_q;
    logic [7:0]                 flags_d;
    logic [7:0]                 flag_set;
    logic [7:0]                 flag_clr;
    logic [7:0]                 en_q;
    logic [7:0]                 gen_q;
    logic [7:0]                 tx_q;
    logic                       policy_q;
    logic [1:0]                 strap_wait_q;
    logic                       soft_q;
    logic [TVEC_POLL_CNT_W-1:0] poll_cnt_q;
    logic [TVEC_POLL_CNT_W-1:0] poll_limit;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // Analog status lines arrive asynchronously; each gets two flops before use.
    assign pin_raw = {clear_policy_strap, overtemp_shutdown, port_unattached,
                      config_pin_over_limit, slow_osc_timer_expired};
    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
        logic [1:0] sync_q;
        always_ff @(posedge core_clk or negedge rst_int_n) begin
            if (!rst_int_n) begin
                sync_q <= 2'h0;
            end else begin
                sync_q <= {sync_q[0], pin_raw[i]};
            end
        end
        assign pin_s[i] = sync_q[1];
    end
    assign osc_s   = pin_s[0];
    assign cc_s    = pin_s[1];
    assign unatt_s = pin_s[2];
    assign ot_s    = pin_s[3];
    assign strap_s = pin_s[4];

    tvec_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .clk       (core_clk),
        .rst_n     (rst_int_n),
        .scl_pin   (scl_pin),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe_n  (sda_oe_n),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    // The policy bit is a read-only strap, caught once its synchroniser holds the pin level.
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            policy_q     <= 1'b0;
            strap_wait_q <= 2'h0;
        end else if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == 2'h2) begin
                policy_q <= strap_s;
            end
        end
    end

    always_comb begin
        reg_rdata = 8'h00;
        case (reg_addr)
            TVEC_OFS_EVT_FLAGS: reg_rdata = flags_q & TVEC_EVT_MASK; // RULE17
            TVEC_OFS_EVT_EN:    reg_rdata = en_q & TVEC_EVT_MASK;
            TVEC_OFS_GEN_CTL:   reg_rdata = {policy_q, gen_q[6:0]};
            TVEC_OFS_TX_CTL:    reg_rdata = tx_q & TVEC_TX_WR_MASK;
            default:            reg_rdata = 8'h00;
        endcase
    end

    always_comb begin
        flag_set = 8'h00;
        flag_set[TVEC_BIT_SLOW_OSC] = osc_s; // RULE1
        flag_set[TVEC_BIT_CONFIG_PIN_OVERVOLTAGE_FAULT] = cc_s & unatt_s; // RULE2
        flag_set[TVEC_BIT_OVERTEMP] = ot_s; // RULE3
        flag_clr = 8'h00;
        // Only the vendor flags live here; the packet-start alert is elsewhere and never sees this clear.
        if (!policy_q && reg_wr && reg_addr == TVEC_OFS_EVT_FLAGS) begin
            flag_clr = reg_wdata & TVEC_EVT_MASK; // RULE5 RULE6
        end else if (policy_q && reg_rd && reg_addr == TVEC_OFS_EVT_FLAGS) begin
            flag_clr = reg_wdata & TVEC_EVT_MASK; // RULE5 RULE6
        end
        // A new event in the clearing cycle survives.
        flags_d = ((flags_q & ~flag_clr) | flag_set) & TVEC_EVT_MASK;
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            flags_q <= TVEC_RST_EVT_FLAGS;
        end else if (soft_q) begin
            flags_q <= TVEC_RST_EVT_FLAGS; // RULE8
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            en_q <= TVEC_RST_EVT_EN;
        end else if (soft_q) begin
            en_q <= TVEC_RST_EVT_EN; // RULE8
        end else if (reg_wr && reg_addr == TVEC_OFS_EVT_EN) begin
            en_q <= reg_wdata & TVEC_EVT_MASK; // RULE4 RULE17
        end
    end

    // Soft reset lasts one cycle: the bit reads one until the defaults land, then clears with them.
    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= !soft_q && reg_wr && reg_addr == TVEC_OFS_GEN_CTL && reg_wdata[TVEC_BIT_SOFT_RESET]; // RULE8
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            gen_q <= TVEC_RST_GEN_CTL; // RULE13
        end else if (soft_q) begin
            gen_q <= TVEC_RST_GEN_CTL; // RULE8 RULE13
        end else begin
            if (reg_wr && reg_addr == TVEC_OFS_GEN_CTL) begin
                gen_q <= reg_wdata & TVEC_GEN_WR_MASK; // RULE10 RULE11 RULE12 RULE17
                gen_q[TVEC_BIT_PD_RESET] <= reg_wdata[TVEC_BIT_PD_RESET] | gen_q[TVEC_BIT_PD_RESET]; // RULE7
            end else if (pd_phy_reset_done) begin
                gen_q[TVEC_BIT_PD_RESET] <= 1'b0; // RULE7
            end
            if (reg_wr && reg_addr == TVEC_OFS_GEN_CTL && reg_wdata[TVEC_BIT_SOFT_RESET]) begin
                gen_q[TVEC_BIT_SOFT_RESET] <= 1'b1; // RULE8
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            tx_q <= TVEC_RST_TX_CTL;
        end else if (soft_q) begin
            tx_q <= TVEC_RST_TX_CTL; // RULE8
        end else if (reg_wr && reg_addr == TVEC_OFS_TX_CTL) begin
            tx_q <= (reg_wdata & TVEC_TX_WR_MASK) | (tx_q & (8'h01 << TVEC_BIT_TX_FRS)); // RULE14 RULE15 RULE17
        end else if (fast_role_swap_sent) begin
            tx_q[TVEC_BIT_TX_FRS] <= 1'b0; // RULE14
        end
    end

    always_comb begin
        case (gen_q[TVEC_POLL_LSB +: 2])
            2'h0:    poll_limit = TVEC_POLL_CNT_W'(POLL_BASE_CYCLES - 1); // RULE11
            2'h1:    poll_limit = TVEC_POLL_CNT_W'(POLL_BASE_CYCLES * 2 - 1);
            2'h2:    poll_limit = TVEC_POLL_CNT_W'(POLL_BASE_CYCLES * 8 - 1);
            default: poll_limit = TVEC_POLL_CNT_W'(POLL_BASE_CYCLES * 16 - 1);
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            poll_cnt_q        <= '0;
            config_pin_sample <= 1'b0;
        end else begin
            config_pin_sample <= 1'b0;
            if (!(drp_toggle_active && unatt_s)) begin
                poll_cnt_q <= '0;
            end else if (gen_q[TVEC_BIT_SAMPLE_POL]) begin
                poll_cnt_q        <= '0;
                config_pin_sample <= role_toggle_due; // RULE10
            end else if (poll_cnt_q >= poll_limit) begin
                poll_cnt_q        <= '0;
                config_pin_sample <= 1'b1; // RULE10 RULE11
            end else begin
                poll_cnt_q <= poll_cnt_q + TVEC_POLL_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            vendor_alert                <= 1'b0;
            pd_phy_state_reset          <= 1'b0;
            whole_chip_soft_reset       <= 1'b0;
            toggle_source_share         <= 2'h0;
            fast_role_swap_req          <= 1'b0;
            test_carrier_continuous_sel <= 1'b0;
        end else begin
            vendor_alert                <= |(flags_q & en_q & TVEC_EVT_MASK); // RULE4 RULE16
            pd_phy_state_reset          <= gen_q[TVEC_BIT_PD_RESET]; // RULE7
            whole_chip_soft_reset       <= soft_q; // RULE8
            toggle_source_share         <= gen_q[TVEC_SHARE_LSB +: 2]; // RULE12
            fast_role_swap_req          <= tx_q[TVEC_BIT_TX_FRS]; // RULE14
            test_carrier_continuous_sel <= tx_q[TVEC_BIT_TX_CARRIER]; // RULE15
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_int_n);

    chk_osc_flag_set: assert property (osc_s && !soft_q |=> flags_q[4]) else $error("osc flag not set"); // RULE1
    chk_config_pin_overvoltage_fault_gate: assert property ($rose(flags_q[3]) |-> $past(cc_s && unatt_s)) // RULE2
        else $error("config_pin_overvoltage_fault set without cause");
    chk_overtemp_set: assert property (ot_s && !soft_q |=> flags_q[2]) else $error("overtemp flag not set"); // RULE3
    chk_alert_enabled: assert property ((flags_q[2] && en_q[2])[*2] |-> vendor_alert) // RULE16
        else $error("alert missing");
    chk_alert_masked: assert property ((en_q == 8'h00)[*2] |-> !vendor_alert) else $error("masked alert"); // RULE4
    chk_w1c_clears: assert property (reg_wr && reg_addr == 8'h90 && !policy_q && reg_wdata[3] && !flag_set[3] // RULE5
        |=> !flags_q[3]) else $error("write-one clear failed");
    chk_rau_clears: assert property (reg_rd && reg_addr == 8'h90 && policy_q && reg_wdata[4] && !flag_set[4] // RULE5
        |=> !flags_q[4]) else $error("read clear failed");
    chk_soft_defaults: assert property (soft_q |=> gen_q == 8'h04 && en_q == 8'h00 && flags_q == 8'h00 ##1 !soft_q) // RULE8
        else $error("soft reset defaults");
    chk_pd_reset_hold: assert property (gen_q[6] && !pd_phy_reset_done && !soft_q |=> gen_q[6] ##1 pd_phy_state_reset) // RULE7
        else $error("pd reset dropped");
    chk_frs_selfclear: assert property (tx_q[1] && fast_role_swap_sent && !reg_wr && !soft_q |=> !tx_q[1]) // RULE14
        else $error("swap request stuck");
    chk_sample_policy: assert property (config_pin_sample && $past(gen_q[4]) |-> $past(role_toggle_due)) // RULE10
        else $error("sample outside toggle");
    chk_reserved_zero: assert property (reg_addr == 8'h90 |-> (reg_rdata & 8'he3) == 8'h00) // RULE17
        else $error("reserved bits set");
endmodule

// [dv/tvec_host_model.sv]
`timescale 1ns/1ns
// Port manager on the serial bus; it only pulls SDA low, the pull-up makes the high level.
module tvec_host_model (
    input  wire logic core_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Ten clocks per phase keeps each SCL level well clear of the five-clock minimum.
    task automatic gap();
        repeat (10) @(negedge core_clk);
    endtask
    // A zero argument makes a start condition, a one makes a stop condition.
    task automatic cond(input logic a);
        sda_low = a;
        gap();
        scl = 1'b1;
        gap();
        sda_low = ~a;
        gap();
        scl = a;
        gap();
    endtask
    // The ninth bit is the acknowledge in either direction.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~tx[i];
            gap();
            scl = 1'b1;
            gap();
            rx[i] = sda;
            scl = 1'b0;
            gap();
        end
    endtask
endmodule

// [dv/tb_tvec_regs.sv]
`timescale 1ns/1ns
module tb_tvec_regs;
    logic        core_clk;
    logic        rst_n;
    logic        scl;
    logic        sda_low;
    logic        sda;
    logic        sda_out;
    logic        sda_oe_n;
    logic [8:0]  stim;
    logic [7:0]  dout;
    logic [31:0] rnd;
    logic [7:0]  rd_seen;
    logic [7:0]  exp_q[$];
    int          miscompares;
    int          check_count;
    int          soft_n;
    int          n;
    int          per[4] = '{1, 2, 8, 16};
    event        rd_ev;
    assign sda = ~sda_low & (sda_oe_n | sda_out);
    always #5 core_clk = ~core_clk;
    tvec_regs #(.POLL_BASE_CYCLES(20)) tvec_regs_i (
        .core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .slow_osc_timer_expired(stim[0]), .config_pin_over_limit(stim[1]), .port_unattached(stim[2]),
        .overtemp_shutdown(stim[3]), .clear_policy_strap(stim[4]), .drp_toggle_active(stim[5]),
        .role_toggle_due(stim[6]), .pd_phy_reset_done(stim[7]), .fast_role_swap_sent(stim[8]),
        .vendor_alert(dout[0]), .pd_phy_state_reset(dout[1]), .whole_chip_soft_reset(dout[2]),
        .config_pin_sample(dout[3]), .toggle_source_share(dout[5:4]), .fast_role_swap_req(dout[6]),
        .test_carrier_continuous_sel(dout[7]));
    tvec_host_model host_i (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic pulse(input int i);
        stim[i] = 1'b1;
        tick(1);
        stim[i] = 1'b0;
        tick(6);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        host_i.cond(1'b0);
        host_i.xfer({8'h40, 1'b1}, r);
        host_i.xfer({a, 1'b1}, r);
        host_i.xfer({d, 1'b1}, r);
        host_i.cond(1'b1);
    endtask
    // The expected value is noted before the bus cycle; the monitor below compares it.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] r;
        exp_q.push_back(e);
        host_i.cond(1'b0);
        host_i.xfer({8'h40, 1'b1}, r);
        host_i.xfer({a, 1'b1}, r);
        host_i.cond(1'b0);
        host_i.xfer({8'h41, 1'b1}, r);
        host_i.xfer({8'hff, 1'b1}, r);
        host_i.cond(1'b1);
        rd_seen = r[8:1];
        ->rd_ev;
    endtask
    always @(rd_ev) chk("read", 16'(rd_seen), 16'(exp_q.pop_front()));
    always @(negedge core_clk) if (dout[2] === 1'b1) soft_n++;
    task automatic next_pulse();
        n = 0;
        do begin
            tick(1);
            n++;
        end while (dout[3] !== 1'b1 && n < 400);
    endtask
    task automatic do_reset(input logic strap);
        rst_n = 1'b0;
        stim[4] = strap;
        tick(3);
        rst_n = 1'b1;
        tick(12);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        stim = '0;
        rnd = nxt(32'h9c50);
        do_reset(1'b0);
        rd(8'h92, 8'h00);
        rd(8'h94, 8'h04);
        rd(8'h95, 8'h00);
        rd(8'h90, 8'h00);
        rd(8'h80, 8'h00);
        wr(8'h92, rnd[7:0] | 8'h1c);
        rd(8'h92, 8'h1c);
        // Random CC over-limit noise while attached must not raise the fault.
        for (int k = 0; k < 20; k++) begin
            rnd = nxt(rnd);
            stim[1] = rnd[0];
            tick(1);
        end
        stim[1] = 1'b0;
        tick(6);
        rd(8'h90, 8'h00);
        stim[2] = 1'b1;
        for (int i = 0; i < 3; i++) begin
            pulse(i + i / 2);
            chk("alert", 16'(dout[0]), 16'h1);
            rd(8'h90, 8'h10 >> i);
            wr(8'h90, 8'h10 >> i);
            rd(8'h90, 8'h00);
            chk("alert", 16'(dout[0]), 16'h0);
        end
        wr(8'h92, 8'h18);
        pulse(3);
        chk("alert", 16'(dout[0]), 16'h0);
        wr(8'h92, 8'h1c);
        chk("alert", 16'(dout[0]), 16'h1);
        wr(8'h90, 8'h04);
        $display("test flags done");
        wr(8'h94, 8'h44);
        chk("pd_reset", 16'(dout[1]), 16'h1);
        rd(8'h94, 8'h44);
        pulse(7);
        chk("pd_reset", 16'(dout[1]), 16'h0);
        rd(8'h94, 8'h04);
        wr(8'h95, 8'hff);
        rd(8'h95, 8'h06);
        wr(8'h95, 8'h00);
        chk("tx_ctl", 16'(dout[7:6]), 16'h1);
        pulse(8);
        chk("fast_swap", 16'(dout[6]), 16'h0);
        $display("test control done");
        stim[5] = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h94, 8'(c * 5));
            chk("share", 16'(dout[5:4]), 16'(c));
            next_pulse();
            next_pulse();
            chk("interval", 16'(n), 16'(per[c] * 20));
        end
        wr(8'h94, 8'h10);
        next_pulse();
        chk("quiet", 16'(n), 16'd400);
        stim[6] = 1'b1;
        next_pulse();
        stim[6] = 1'b0;
        chk("on_toggle", 16'(n <= 2), 16'h1);
        stim[5] = 1'b0;
        wr(8'h92, 8'h1c);
        soft_n = 0;
        wr(8'h94, 8'h20);
        chk("soft_pulses", 16'(soft_n), 16'h1);
        rd(8'h92, 8'h00);
        rd(8'h94, 8'h04);
        wr(8'h92, 8'h1c);
        rd(8'h92, 8'h1c);
        $display("test resets done");
        do_reset(1'b1);
        rd(8'h94, 8'h84);
        pulse(3);
        rd(8'h90, 8'h04);
        rd(8'h90, 8'h00);
        $display("test read_clear done");
        print_verdict();
    end
    initial begin
        #900000;
        miscompares++;
        print_verdict();
    end
endmodule
